// [verilog/host_pci_bridge.sv]
// Host-to-PCI cycle bridge: reads, posted writes, bursts, config cycles
`timescale 1ns/100ps
`default_nettype none
module host_pci_bridge
(
    // Clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RESET,
    // Host request
    input  wire logic        HOST_REQ,
    input  wire logic        HOST_WRITE,
    input  wire logic        HOST_IO,
    input  wire logic [29:0] HOST_ADDR,
    input  wire logic [3:0]  HOST_BE_N,
    input  wire logic [31:0] HOST_WDATA,
    output logic             HOST_ACK,
    output logic      [31:0] HOST_RDATA,
    // PCI address/data and command
    input  wire logic [31:0] AD_IN,
    output logic      [31:0] AD_OUT,
    output logic             AD_OE,
    output logic      [3:0]  CBE_N_OUT,
    output logic             CBE_OE,
    // PCI control
    output logic             FRAME_N_OUT,
    output logic             FRAME_OE,
    output logic             IRDY_N_OUT,
    output logic             IRDY_OE,
    input  wire logic        TRDY_N_IN,
    output logic             TRDY_N_OUT,
    output logic             TRDY_OE,
    output logic             DEVSEL_N_OUT,
    output logic             DEVSEL_OE
);
    pci_bridge_pkg::seq_state_e st_r;

    logic [31:0] conf_addr_r;
    logic [31:0] cur_addr_r;
    logic [3:0]  cur_cmd_r;
    logic [3:0]  cur_be_n_r;
    logic [31:0] cur_data_r;
    logic        cur_self_r;
    logic        nxt_valid_r;
    logic [31:0] nxt_addr_r;
    logic [3:0]  nxt_be_n_r;
    logic [31:0] nxt_data_r;
    logic        frame_n_r;
    logic        rd_done_r;
    logic [31:0] rdata_r;

    logic        is_ca;
    logic        is_cd;
    logic [31:0] cfg_pci_addr;
    logic [31:0] req_addr;
    logic [3:0]  req_cmd;
    logic        req_self;
    logic        take;
    logic        local_wr;
    logic        local_rd;
    logic        done;
    logic        merge_ok;
    logic [31:0] tail_addr;
    logic        cur_write;
    logic [31:0] cfg_rdata;

    // ------------------------------------------------------------------
    // Host request decode
    // ------------------------------------------------------------------
    assign is_ca = HOST_IO && HOST_ADDR == pci_bridge_pkg::CONF_ADDR_PORT
                   && HOST_BE_N == 4'h0;
    assign is_cd = HOST_IO && HOST_ADDR == pci_bridge_pkg::CONF_DATA_PORT
                   && conf_addr_r[pci_bridge_pkg::CFG_EN_BIT];

    // Bus 0 gives a type 0 cycle with a one-hot select line for devices 0 to 20 (none for 21 to 31), others type 1
    always_comb
    begin
        if (conf_addr_r[23:16] == 8'h00)
            cfg_pci_addr = ((32'h0000_0001 << ({1'b0, conf_addr_r[15:11]}
                           + pci_bridge_pkg::IDSEL_BASE)) & pci_bridge_pkg::IDSEL_MASK)
                           | {21'h00_0000, conf_addr_r[10:2], 2'h0};
        else
            cfg_pci_addr = {8'h00, conf_addr_r[23:2], 2'h1};
    end

    always_comb
    begin
        if (is_cd)
        begin
            req_addr = cfg_pci_addr;
            req_cmd  = HOST_WRITE ? pci_bridge_pkg::CMD_CFG_WR : pci_bridge_pkg::CMD_CFG_RD;
        end
        else if (HOST_IO)
        begin
            req_addr = {HOST_ADDR, 2'h0};
            req_cmd  = HOST_WRITE ? pci_bridge_pkg::CMD_IO_WR : pci_bridge_pkg::CMD_IO_RD;
        end
        else
        begin
            req_addr = {HOST_ADDR, 2'h0};
            req_cmd  = HOST_WRITE ? pci_bridge_pkg::CMD_MEM_WR : pci_bridge_pkg::CMD_MEM_RD;
        end
    end

    // Type 0 cycle whose select line is AD16 addresses the bridge itself
    assign req_self = is_cd && req_addr[1:0] == 2'h0
                      && req_addr[pci_bridge_pkg::SELF_IDSEL_BIT];

    assign take     = st_r == pci_bridge_pkg::ST_IDLE && HOST_REQ && !is_ca;
    assign local_wr = st_r == pci_bridge_pkg::ST_IDLE && HOST_REQ && is_ca && HOST_WRITE;
    assign local_rd = st_r == pci_bridge_pkg::ST_IDLE && HOST_REQ && is_ca && !HOST_WRITE;
    assign cur_write = cur_cmd_r[0];

    // Self cycles need no outside TRDY#: the bridge answers its own phase
    assign done = st_r == pci_bridge_pkg::ST_DATA && (cur_self_r || !TRDY_N_IN);

    // ------------------------------------------------------------------
    // Burst merge: only contiguous memory writes, and only while FRAME#
    // can still be kept low; once it rises the burst is closed
    // ------------------------------------------------------------------
    assign tail_addr = nxt_valid_r ? nxt_addr_r : cur_addr_r;
    assign merge_ok  = HOST_REQ && HOST_WRITE && !HOST_IO
                       && cur_cmd_r == pci_bridge_pkg::CMD_MEM_WR
                       && {HOST_ADDR, 2'h0} == tail_addr + pci_bridge_pkg::DWORD_STEP
                       && ((st_r == pci_bridge_pkg::ST_ADDR && !nxt_valid_r)
                           || (st_r == pci_bridge_pkg::ST_DATA && !frame_n_r && done));

    // Writes are acknowledged when taken, reads once data is back
    assign HOST_ACK   = (take && HOST_WRITE) || merge_ok || local_wr || rd_done_r;
    assign HOST_RDATA = rdata_r;

    // ------------------------------------------------------------------
    // Sequencer and FRAME# control
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            st_r      <= pci_bridge_pkg::ST_IDLE;
            frame_n_r <= 1'b1;
        end
        else
        begin
            unique case (st_r)
                pci_bridge_pkg::ST_IDLE:
                begin
                    if (take)
                        st_r <= pci_bridge_pkg::ST_ADDR;
                    else if (local_rd)
                        st_r <= pci_bridge_pkg::ST_TURN;
                end
                pci_bridge_pkg::ST_ADDR:
                begin
                    st_r      <= pci_bridge_pkg::ST_DATA;
                    frame_n_r <= !merge_ok;
                end
                pci_bridge_pkg::ST_DATA:
                begin
                    if (done && nxt_valid_r)
                        frame_n_r <= !merge_ok;
                    else if (done)
                    begin
                        st_r      <= pci_bridge_pkg::ST_TURN;
                        frame_n_r <= 1'b1;
                    end
                end
                pci_bridge_pkg::ST_TURN:
                    st_r <= pci_bridge_pkg::ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Posted data path: current phase and one queued burst beat
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            cur_addr_r  <= 32'h0000_0000;
            cur_cmd_r   <= 4'h0;
            cur_be_n_r  <= 4'hF;
            cur_data_r  <= 32'h0000_0000;
            cur_self_r  <= 1'b0;
            nxt_valid_r <= 1'b0;
            nxt_addr_r  <= 32'h0000_0000;
            nxt_be_n_r  <= 4'hF;
            nxt_data_r  <= 32'h0000_0000;
        end
        else
        begin
            if (take)
            begin
                cur_addr_r  <= req_addr;
                cur_cmd_r   <= req_cmd;
                cur_be_n_r  <= HOST_BE_N;
                cur_data_r  <= HOST_WDATA;
                cur_self_r  <= req_self;
                nxt_valid_r <= 1'b0;
            end
            else if (done && nxt_valid_r)
            begin
                cur_addr_r  <= nxt_addr_r;
                cur_be_n_r  <= nxt_be_n_r;
                cur_data_r  <= nxt_data_r;
                nxt_valid_r <= merge_ok;
            end
            else if (merge_ok)
                nxt_valid_r <= 1'b1;
            if (merge_ok)
            begin
                nxt_addr_r <= {HOST_ADDR, 2'h0};
                nxt_be_n_r <= HOST_BE_N;
                nxt_data_r <= HOST_WDATA;
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration address register and read return
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            conf_addr_r <= pci_bridge_pkg::CONF_ADDR_RST;
        else if (local_wr)
            conf_addr_r <= HOST_WDATA;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            rd_done_r <= 1'b0;
            rdata_r   <= 32'h0000_0000;
        end
        else
        begin
            rd_done_r <= local_rd || (done && !nxt_valid_r && !cur_write);
            if (local_rd)
                rdata_r <= conf_addr_r;
            else if (done && !cur_write)
                rdata_r <= cur_self_r ? cfg_rdata : AD_IN;
        end
    end

    // ------------------------------------------------------------------
    // Own configuration space as PCI target
    // ------------------------------------------------------------------
    own_config_space u_cfg
    (
        .clk   (REF_CLK),
        .rst   (RESET),
        .wr_en (done && cur_self_r && cur_write),
        .idx   (cur_addr_r[7:2]),
        .be_n  (cur_be_n_r),
        .wdata (cur_data_r),
        .rdata (cfg_rdata)
    );

    // ------------------------------------------------------------------
    // PCI pin drive; TURN drives controls high one clock before release
    // ------------------------------------------------------------------
    always_comb
    begin
        AD_OUT = (st_r == pci_bridge_pkg::ST_ADDR) ? cur_addr_r
                 : (cur_write ? cur_data_r : cfg_rdata);
        AD_OE  = st_r == pci_bridge_pkg::ST_ADDR
                 || (st_r == pci_bridge_pkg::ST_DATA && (cur_write || cur_self_r));
        CBE_N_OUT = (st_r == pci_bridge_pkg::ST_ADDR) ? cur_cmd_r : cur_be_n_r;
        CBE_OE    = st_r == pci_bridge_pkg::ST_ADDR || st_r == pci_bridge_pkg::ST_DATA;
        FRAME_N_OUT = (st_r == pci_bridge_pkg::ST_ADDR) ? 1'b0
                      : (st_r == pci_bridge_pkg::ST_DATA ? frame_n_r : 1'b1);
        FRAME_OE    = st_r != pci_bridge_pkg::ST_IDLE;
        IRDY_N_OUT  = st_r != pci_bridge_pkg::ST_DATA;
        IRDY_OE     = st_r == pci_bridge_pkg::ST_DATA || st_r == pci_bridge_pkg::ST_TURN;
        // Claim and ready come together with IRDY# for self cycles
        DEVSEL_N_OUT = !(st_r == pci_bridge_pkg::ST_DATA && cur_self_r);
        TRDY_N_OUT   = !(st_r == pci_bridge_pkg::ST_DATA && cur_self_r);
        DEVSEL_OE    = cur_self_r && (st_r == pci_bridge_pkg::ST_DATA
                                      || st_r == pci_bridge_pkg::ST_TURN);
        TRDY_OE      = DEVSEL_OE;
    end
endmodule // host_pci_bridge
`default_nettype wire

// [pkg/pci_bridge_pkg.sv]
// Shared constants and types for the host-to-PCI cycle bridge
package pci_bridge_pkg;

    // ------------------------------------------------------------------
    // Host I/O ports (dword index, byte address divided by four)
    // ------------------------------------------------------------------
    localparam logic [29:0] CONF_ADDR_PORT = 30'h0000_033E;
    localparam logic [29:0] CONF_DATA_PORT = 30'h0000_033F;

    // ------------------------------------------------------------------
    // Configuration address register layout
    // ------------------------------------------------------------------
    localparam int          CFG_EN_BIT     = 31;
    localparam logic [5:0]  IDSEL_BASE     = 6'h0B;
    localparam int          SELF_IDSEL_BIT = 16;
    localparam logic [31:0] IDSEL_MASK     = 32'hFFFF_F800;
    localparam logic [31:0] CONF_ADDR_RST  = 32'h0000_0000;
    localparam logic [31:0] DWORD_STEP     = 32'h0000_0004;

    // ------------------------------------------------------------------
    // PCI bus commands
    // ------------------------------------------------------------------
    localparam logic [3:0] CMD_IO_RD  = 4'h2;
    localparam logic [3:0] CMD_IO_WR  = 4'h3;
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_MEM_WR = 4'h7;
    localparam logic [3:0] CMD_CFG_RD = 4'hA;
    localparam logic [3:0] CMD_CFG_WR = 4'hB;

    // ------------------------------------------------------------------
    // Own configuration space
    // ------------------------------------------------------------------
    localparam int          CFG_ENTRIES = 16;
    // Identity word is arbitrary
    localparam logic [31:0] CFG_ID_WORD = 32'h0001_1234;

    // ------------------------------------------------------------------
    // Master sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ADDR = 4'h2,
        ST_DATA = 4'h4,
        ST_TURN = 4'h8
    } seq_state_e;

endpackage

// [verilog/own_config_space.sv]
// Bridge's own configuration registers, reached as PCI target
`timescale 1ns/100ps
`default_nettype none
module own_config_space
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Access from the self-target path
    input  wire logic        wr_en,
    input  wire logic [5:0]  idx,
    input  wire logic [3:0]  be_n,
    input  wire logic [31:0] wdata,
    output logic      [31:0] rdata
);
    logic [31:0] word_r [pci_bridge_pkg::CFG_ENTRIES];

    // ------------------------------------------------------------------
    // Storage, entry 0 holds a fixed identity
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < pci_bridge_pkg::CFG_ENTRIES; g = g + 1)
        begin : g_word
            if (g == 0)
            begin : g_id
                assign word_r[g] = pci_bridge_pkg::CFG_ID_WORD;
            end
            else
            begin : g_rw
                always_ff @(posedge clk)
                begin
                    if (rst)
                        word_r[g] <= 32'h0000_0000;
                    else if (wr_en && idx == 6'(g))
                    begin
                        for (int b = 0; b < 4; b++)
                            if (!be_n[b])
                                word_r[g][b*8 +: 8] <= wdata[b*8 +: 8];
                    end
                end
            end
        end
    endgenerate

    // Unimplemented offsets read as zero
    always_comb
    begin
        if (idx < 6'(pci_bridge_pkg::CFG_ENTRIES))
            rdata = word_r[idx[3:0]];
        else
            rdata = 32'h0000_0000;
    end
endmodule // own_config_space
`default_nettype wire

// [tb/pci_target_model.sv]
// Behavioural PCI target standing on the far side of the bridge
`timescale 1ns/100ps
`default_nettype none
module pci_target_model
#(
    parameter logic [31:0] RD_KEY = 32'h5A5A_0F0F
)
(
    // Clock, reset and bus wires
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        frame_n,
    input  wire logic        irdy_n,
    input  wire logic        claimed,
    input  wire logic [31:0] ad,
    input  wire logic [3:0]  cbe_n,
    // Wait states before ready, and what it drives back
    input  wire logic [2:0]  wait_cyc,
    output logic             trdy_n,
    output logic      [31:0] ad_out
);
    logic        fprev_r;
    logic        rd_r;
    logic [2:0]  cnt_r;
    logic [31:0] addr_r;
    logic [31:0] noise_r;

    // Silent while the bridge claims its own cycle; >= keeps a late wait change from hanging
    assign trdy_n = !(!irdy_n && !claimed && cnt_r >= wait_cyc);
    // Released lines show a moving pattern, never the last value
    assign ad_out = (rd_r && !trdy_n) ? (addr_r ^ RD_KEY) : noise_r;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            fprev_r <= 1'b1;
            rd_r    <= 1'b0;
            cnt_r   <= 3'h0;
            noise_r <= 32'h0000_0001;
        end
        else
        begin
            fprev_r <= frame_n;
            noise_r <= {noise_r[30:0], ~noise_r[31]};
            cnt_r   <= (!irdy_n && !claimed && trdy_n) ? cnt_r + 3'h1 : 3'h0;
            if (fprev_r && !frame_n)
            begin
                addr_r <= ad;
                rd_r   <= !cbe_n[0];
            end
        end
    end
endmodule // pci_target_model
`default_nettype wire

// [tb/host_pci_bridge_checker.sv]
// Concurrent checks on the host-to-PCI cycle bridge ports
`timescale 1ns/100ps
`default_nettype none
module host_pci_bridge_checker
(
    // Clock, reset and host side
    input wire logic        REF_CLK,
    input wire logic        RESET,
    input wire logic        HOST_REQ,
    input wire logic        HOST_WRITE,
    input wire logic        HOST_IO,
    input wire logic [29:0] HOST_ADDR,
    input wire logic [31:0] HOST_WDATA,
    input wire logic        HOST_ACK,
    // PCI side
    input wire logic [31:0] AD_OUT,
    input wire logic        AD_OE,
    input wire logic [3:0]  CBE_N_OUT,
    input wire logic        FRAME_N_OUT,
    input wire logic        FRAME_OE,
    input wire logic        IRDY_N_OUT,
    input wire logic        IRDY_OE,
    input wire logic        TRDY_N_OUT,
    input wire logic        TRDY_OE,
    input wire logic        DEVSEL_N_OUT,
    input wire logic        DEVSEL_OE
);
    logic [31:0] cf8_r;
    wire logic idle = !FRAME_OE && !IRDY_OE;
    wire logic aph = FRAME_OE && !FRAME_N_OUT && IRDY_N_OUT;
    wire logic cfg_cmd = CBE_N_OUT inside {pci_bridge_pkg::CMD_CFG_RD, pci_bridge_pkg::CMD_CFG_WR};
    wire logic self_aph = aph && cfg_cmd && cf8_r[23:11] == 13'h0005;
    wire logic dport = idle && HOST_REQ && HOST_IO && HOST_ADDR == pci_bridge_pkg::CONF_DATA_PORT;

    // Shadow of the config address register, from accepted host writes
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            cf8_r <= 32'h0;
        else if (HOST_ACK && HOST_WRITE && HOST_IO && HOST_ADDR == pci_bridge_pkg::CONF_ADDR_PORT)
            cf8_r <= HOST_WDATA;
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    property p_cfg_cmd; dport && cf8_r[31] |=> aph && cfg_cmd; endproperty
    a_cfg_cmd: assert property (p_cfg_cmd)
        else $error("data port access gave no config command");
    property p_io_plain; dport && !cf8_r[31] |=> aph && CBE_N_OUT[3:1] == 3'b001; endproperty
    a_io_plain: assert property (p_io_plain)
        else $error("data port access not a plain I/O cycle");
    property p_self_sel; self_aph |-> AD_OE && AD_OUT[16]; endproperty
    a_self_sel: assert property (p_self_sel)
        else $error("own select line not driven in address phase");
    property p_self_claim; self_aph |=> DEVSEL_OE && !DEVSEL_N_OUT; endproperty
    a_self_claim: assert property (p_self_claim)
        else $error("own config cycle not claimed");
    property p_target_own; TRDY_OE |-> IRDY_OE && DEVSEL_OE; endproperty
    a_target_own: assert property (p_target_own)
        else $error("target ready driven outside own cycle");
    property p_self_done; self_aph |=> (!IRDY_N_OUT && TRDY_OE && !TRDY_N_OUT) ##1 IRDY_N_OUT; endproperty
    a_self_done: assert property (p_self_done)
        else $error("own config cycle did not complete in one phase");
    property p_post_ack; idle && HOST_REQ && HOST_WRITE && !HOST_IO |-> HOST_ACK; endproperty
    a_post_ack: assert property (p_post_ack)
        else $error("memory write not accepted at once");
    property p_burst_hold; aph && HOST_ACK |=> !FRAME_N_OUT && !IRDY_N_OUT; endproperty
    a_burst_hold: assert property (p_burst_hold)
        else $error("merged write did not keep frame low");

    c_self: cover property (self_aph);
    c_merge: cover property (aph && HOST_ACK);
    c_plain_io: cover property (dport && !cf8_r[31]);
    c_ext_cfg: cover property (aph && cfg_cmd && !self_aph);
endmodule // host_pci_bridge_checker

bind host_pci_bridge host_pci_bridge_checker u_chk
(
    .REF_CLK, .RESET, .HOST_REQ, .HOST_WRITE, .HOST_IO, .HOST_ADDR, .HOST_WDATA, .HOST_ACK,
    .AD_OUT, .AD_OE, .CBE_N_OUT, .FRAME_N_OUT, .FRAME_OE, .IRDY_N_OUT, .IRDY_OE,
    .TRDY_N_OUT, .TRDY_OE, .DEVSEL_N_OUT, .DEVSEL_OE
);
`default_nettype wire

// [tb/host_to_pci_cycle_bridge_tb_top.sv]
// Self-checking testbench for the host-to-PCI cycle bridge
`timescale 1ns/100ps
`default_nettype none
module host_to_pci_cycle_bridge_tb_top;
    localparam logic [31:0] KEY = 32'h5A5A_0F0F;
    logic        REF_CLK = 1'b0, RESET = 1'b1, HOST_REQ = 1'b0, HOST_WRITE = 1'b0;
    logic        HOST_IO = 1'b0, fprev = 1'b1, wcyc = 1'b0, m_trdy_n;
    logic        HOST_ACK, AD_OE, CBE_OE, FRAME_N_OUT, FRAME_OE, IRDY_N_OUT, IRDY_OE;
    logic        TRDY_N_OUT, TRDY_OE, DEVSEL_N_OUT, DEVSEL_OE;
    logic [29:0] HOST_ADDR = 30'h0;
    logic [3:0]  HOST_BE_N = 4'h0, CBE_N_OUT;
    logic [2:0]  wait_cyc = 3'h0;
    logic [31:0] HOST_WDATA = 32'h0, HOST_RDATA, AD_OUT, m_ad, a32, d, cf;
    logic [35:0] addr_q[$], wr_q[$];
    logic [31:0] rd_q[$];
    int          n_mismatch = 0, cmp_count = 0, seed = 32'h38F9E28C;
    // Wire levels: FRAME# and IRDY# pulled up when the bridge releases them; TRDY# and AD fall back to the target model
    wire logic        frame_w = FRAME_OE ? FRAME_N_OUT : 1'b1;
    wire logic        irdy_w = IRDY_OE ? IRDY_N_OUT : 1'b1;
    wire logic        trdy_w = TRDY_OE ? TRDY_N_OUT : m_trdy_n;
    wire logic [31:0] ad_w = AD_OE ? AD_OUT : m_ad;

    host_pci_bridge u_dut (.REF_CLK, .RESET, .HOST_REQ, .HOST_WRITE, .HOST_IO, .HOST_ADDR,
        .HOST_BE_N, .HOST_WDATA, .HOST_ACK, .HOST_RDATA, .AD_IN(ad_w), .AD_OUT, .AD_OE,
        .CBE_N_OUT, .CBE_OE, .FRAME_N_OUT, .FRAME_OE, .IRDY_N_OUT, .IRDY_OE, .TRDY_N_IN(trdy_w),
        .TRDY_N_OUT, .TRDY_OE, .DEVSEL_N_OUT, .DEVSEL_OE);
    pci_target_model #(.RD_KEY(KEY)) u_target (.clk(REF_CLK), .rst(RESET), .frame_n(frame_w),
        .irdy_n(irdy_w), .claimed(DEVSEL_OE), .ad(ad_w), .cbe_n(CBE_N_OUT),
        .wait_cyc(wait_cyc), .trdy_n(m_trdy_n), .ad_out(m_ad));

    always #20 REF_CLK = ~REF_CLK;

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Request held until acknowledged; left raised so a burst beat can follow at once
    task automatic host_op(input logic w, io, input logic [29:0] a, input logic [31:0] wd);
        int n;
        HOST_REQ <= 1'b1;
        HOST_WRITE <= w;
        HOST_IO <= io;
        HOST_ADDR <= a;
        HOST_WDATA <= wd;
        n = 0;
        do @(posedge REF_CLK); while (HOST_ACK !== 1'b1 && ++n < 300);
        if (n >= 300)
            n_mismatch++;
    endtask

    task automatic host_rel;
        HOST_REQ <= 1'b0;
        HOST_BE_N <= 4'h0;
        @(posedge REF_CLK);
    endtask

    // -----------------------------------------------------------------
    // Monitor: address phases, completed write beats, read returns
    // -----------------------------------------------------------------
    always @(posedge REF_CLK)
    begin
        if (!RESET)
        begin
            fprev <= frame_w;
            if (fprev && !frame_w)
            begin
                check({CBE_N_OUT, AD_OUT}, addr_q.size() ? addr_q.pop_front() : 'X);
                wcyc <= CBE_N_OUT[0];
            end
            if (!irdy_w && !trdy_w && wcyc)
                check({CBE_N_OUT, AD_OUT}, wr_q.size() ? wr_q.pop_front() : 'X);
            if (HOST_ACK && HOST_REQ && !HOST_WRITE)
                check(HOST_RDATA, rd_q.size() ? rd_q.pop_front() : 'X);
        end
    end

    initial
    begin
        #400_000;
        n_mismatch++;
        tally_and_finish;
    end

    initial
    begin
        repeat (4) @(posedge REF_CLK);
        RESET <= 1'b0;
        @(posedge REF_CLK);
        for (int k = 0; k < 2; k++)
        begin
            d = $random(seed);
            addr_q.push_back({k ? pci_bridge_pkg::CMD_IO_WR : pci_bridge_pkg::CMD_IO_RD,
                pci_bridge_pkg::CONF_DATA_PORT, 2'b00});
            if (k)
                wr_q.push_back(d);
            else
                rd_q.push_back({pci_bridge_pkg::CONF_DATA_PORT, 2'b00} ^ KEY);
            host_op(k[0], 1'b1, pci_bridge_pkg::CONF_DATA_PORT, d);
            host_rel;
        end
        // Own space: a writable dword, then the read-only identity word
        for (int k = 0; k < 2; k++)
        begin
            d = $random(seed);
            cf = 32'h8000_2800 | (k ? 32'h0 : {26'h0, d[3:0] | 4'h1, 2'b00});
            a32 = 32'h0001_0000 | {21'h0, cf[10:0]};
            host_op(1'b1, 1'b1, pci_bridge_pkg::CONF_ADDR_PORT, cf);
            host_rel;
            rd_q.push_back(cf);
            host_op(1'b0, 1'b1, pci_bridge_pkg::CONF_ADDR_PORT, 32'h0);
            host_rel;
            addr_q.push_back({pci_bridge_pkg::CMD_CFG_WR, a32});
            wr_q.push_back(d);
            host_op(1'b1, 1'b1, pci_bridge_pkg::CONF_DATA_PORT, d);
            host_rel;
            addr_q.push_back({pci_bridge_pkg::CMD_CFG_RD, a32});
            rd_q.push_back(k ? pci_bridge_pkg::CFG_ID_WORD : d);
            host_op(1'b0, 1'b1, pci_bridge_pkg::CONF_DATA_PORT, 32'h0);
            host_rel;
        end
        // Config cycles that leave the bridge: device 2 on bus 0, then type 1 to bus 1
        for (int k = 0; k < 2; k++)
        begin
            cf = k ? 32'h8001_1810 : 32'h8000_1008;
            a32 = k ? 32'h0001_1811 : 32'h0000_2008;
            host_op(1'b1, 1'b1, pci_bridge_pkg::CONF_ADDR_PORT, cf);
            host_rel;
            addr_q.push_back({pci_bridge_pkg::CMD_CFG_RD, a32});
            rd_q.push_back(a32 ^ KEY);
            host_op(1'b0, 1'b1, pci_bridge_pkg::CONF_DATA_PORT, 32'h0);
            host_rel;
        end
        host_op(1'b1, 1'b1, pci_bridge_pkg::CONF_ADDR_PORT, 32'h0);
        host_rel;
        // Random reads and write bursts of one to four beats, varied wait states
        for (int i = 0; i < 24; i++)
        begin
            d = $random(seed);
            a32 = $random(seed);
            wait_cyc <= {1'b0, d[1:0]};
            addr_q.push_back({d[4] ? pci_bridge_pkg::CMD_MEM_RD : pci_bridge_pkg::CMD_MEM_WR,
                a32[29:0], 2'b00});
            if (d[4])
            begin
                rd_q.push_back({a32[29:0], 2'b00} ^ KEY);
                host_op(1'b0, 1'b0, a32[29:0], d);
            end
            else
            begin
                // Random byte enables ride along with every beat of the burst
                HOST_BE_N <= d[10:7];
                for (int b = 0; b <= int'(d[6:5]); b++)
                begin
                    wr_q.push_back({d[10:7], d + 32'(b)});
                    host_op(1'b1, 1'b0, a32[29:0] + 30'(b), d + 32'(b));
                end
            end
            host_rel;
        end
        repeat (40) @(posedge REF_CLK);
        check(36'(addr_q.size() + wr_q.size() + rd_q.size()), 36'h0);
        tally_and_finish;
    end
endmodule // host_to_pci_cycle_bridge_tb_top
`default_nettype wire
